// ===== hdl/afegc_divider.sv
// Programmable tick divider used for sample pacing.
`timescale 1ns/1ps
module afegc_divider #(
  parameter int W = 10
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic run,
  input wire logic tick,
  input wire logic [W-1:0] div,
  output logic strobe
);

  logic [W-1:0] cnt_reg;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_reg <= '0;
      strobe <= 1'b0;
    end else if (!run) begin
      cnt_reg <= '0;
      strobe <= 1'b0;
    end else begin
      strobe <= 1'b0;
      if (tick) begin
        if (cnt_reg >= div - W'(1)) begin
          cnt_reg <= '0;
          strobe <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + W'(1);
        end
      end
    end
  end

endmodule // afegc_divider

// ===== hdl/afegc_general_config.sv
// General configuration register of the front end with its derived controls.
`timescale 1ns/1ps
// Function
// - Clock select picks 32768, 32000 or 31968.78 Hz.
// - All master rates derive from 32.768 kHz reference.
// - Clock code sets timing resolution and progression.
// - Bit 19 powers cardiac channel; beat timing needs it.
// - Bit 18 enables impedance channel.
// - Pace detection only with cardiac channel on.
// - Impedance lead-off mode: off, under, over, both.
// - Impedance lead-off needs channel; drives range flags.
// - DC lead-off code 01 on; reserved codes forbidden.
// - DC lead-off needs active channel; own flag.
// - Polarity clear pulls positive input up.
// - Magnitude codes 0 to 100 nA; 000 disconnects.
// - Threshold codes select 300 to 500 mV.
// - Bias mode cardiac or impedance, channel needed.
// - Bias mode forced 00 without channel enable.
// - Bias resistor 50/100/200 Mohm, resets to 01.
// - Bit 1 biases positive input to mid-supply.
// - Bit 0 biases negative input to mid-supply.
// - Cardiac sample rates depend on clock code.
// - Pace resolution and record depth follow clock.
// - Impedance rates from rate bit and clock.
// - Calibration resolution tracks master clock.
// - Low-power lead-on only while cardiac disabled.
module afegc_general_config (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [6:0] REG_ADDR,
  input wire logic [23:0] REG_WDATA,
  output logic [23:0] REG_RDATA,
  output logic REG_RVALID,
  input wire logic REF_TICK,
  input wire logic [1:0] CARDIAC_RATE_SEL,
  input wire logic IMPEDANCE_RATE_SEL,
  input wire logic IMP_OVER_RANGE,
  input wire logic IMP_UNDER_RANGE,
  input wire logic DC_LEADOFF_DETECT,
  output logic MASTER_TICK,
  output logic CARDIAC_CHANNEL_ON,
  output logic IMPEDANCE_CHANNEL_ON,
  output logic PACE_DETECT_ON,
  output logic BEAT_INTERVAL_ON,
  output logic LOW_POWER_LEAD_ON_ACTIVE,
  output logic IMPEDANCE_OVER_RANGE_FLAG,
  output logic IMPEDANCE_UNDER_RANGE_FLAG,
  output logic DC_LEADOFF_FLAG,
  output logic LEADOFF_SOURCE_CONNECTED,
  output logic POSITIVE_INPUT_PULLUP,
  output logic [6:0] LEADOFF_CURRENT_NA,
  output logic [9:0] LEADOFF_THRESHOLD_MV,
  output logic [1:0] RESISTIVE_BIAS_MODE,
  output logic [7:0] BIAS_RESISTOR_MOHM,
  output logic POSITIVE_INPUT_BIAS,
  output logic NEGATIVE_INPUT_BIAS,
  output logic [15:0] TIMING_RESOLUTION_NS,
  output logic [15:0] CALIBRATION_RESOLUTION_NS,
  output logic [9:0] PACE_RECORD_DEPTH,
  output logic CARDIAC_SAMPLE_STROBE,
  output logic IMPEDANCE_SAMPLE_STROBE
);

  logic [23:0] config_reg;
  logic [23:0] config_next;
  logic cfg_write;
  logic [1:0] clk_sel;
  logic ecg_on;
  logic bioz_on;
  logic [1:0] bias_req;
  logic bias_ok;
  logic [9:0] ecg_div;
  logic [9:0] ecg_div_full;
  logic [10:0] bioz_div;
  logic [1:0] bloff;

  function automatic logic [1:0] fld2(input logic [23:0] word, input int pos);
    fld2 = word[pos +: 2];
  endfunction

  // ==========================================================================
  // Register write path
  // ==========================================================================
  assign cfg_write = REG_WR && (REG_ADDR == afegc_pkg::ADDR_GENERAL_CONFIG);
  assign bias_req = fld2(REG_WDATA, afegc_pkg::POS_RESISTIVE_BIAS_MODE);

  always_comb begin
    // A bias mode is accepted only when this same write also enables its channel.
    bias_ok = 1'b0;
    if (bias_req == afegc_pkg::BIAS_CARDIAC) begin
      bias_ok = REG_WDATA[afegc_pkg::POS_CARDIAC_ON];
    end else if (bias_req == afegc_pkg::BIAS_IMPEDANCE) begin
      bias_ok = REG_WDATA[afegc_pkg::POS_IMPEDANCE_ON];
    end
    config_next = REG_WDATA & afegc_pkg::GENERAL_CONFIG_WMASK;
    if (!bias_ok) begin
      config_next[afegc_pkg::POS_RESISTIVE_BIAS_MODE +: 2] = afegc_pkg::BIAS_OFF;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      config_reg <= afegc_pkg::GENERAL_CONFIG_RESET;
    end else if (cfg_write) begin
      config_reg <= config_next;
    end
  end

  // Reads answer one cycle later; unmapped addresses return zero.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= 24'h000000;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD && REG_ADDR == afegc_pkg::ADDR_GENERAL_CONFIG) begin
        REG_RDATA <= config_reg;
      end else begin
        REG_RDATA <= 24'h000000;
      end
    end
  end

  // ==========================================================================
  // Channel enables and detection gating
  // ==========================================================================
  assign clk_sel = fld2(config_reg, afegc_pkg::POS_MASTER_CLOCK_SELECT);
  assign ecg_on = config_reg[afegc_pkg::POS_CARDIAC_ON];
  assign bioz_on = config_reg[afegc_pkg::POS_IMPEDANCE_ON];
  assign bloff = fld2(config_reg, afegc_pkg::POS_IMP_LEADOFF_MODE);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      CARDIAC_CHANNEL_ON <= 1'b0;
      IMPEDANCE_CHANNEL_ON <= 1'b0;
      PACE_DETECT_ON <= 1'b0;
      BEAT_INTERVAL_ON <= 1'b0;
      LOW_POWER_LEAD_ON_ACTIVE <= 1'b0;
      IMPEDANCE_OVER_RANGE_FLAG <= 1'b0;
      IMPEDANCE_UNDER_RANGE_FLAG <= 1'b0;
      DC_LEADOFF_FLAG <= 1'b0;
    end else begin
      CARDIAC_CHANNEL_ON <= ecg_on;
      IMPEDANCE_CHANNEL_ON <= bioz_on;
      PACE_DETECT_ON <= config_reg[afegc_pkg::POS_PACE_ON] && ecg_on;
      BEAT_INTERVAL_ON <= ecg_on;
      LOW_POWER_LEAD_ON_ACTIVE <= !ecg_on &&
        (fld2(config_reg, afegc_pkg::POS_LOW_POWER_LEAD_ON) == afegc_pkg::ULP_ON);
      IMPEDANCE_OVER_RANGE_FLAG <= bioz_on && bloff[1] && IMP_OVER_RANGE;
      IMPEDANCE_UNDER_RANGE_FLAG <= bioz_on && bloff[0] && IMP_UNDER_RANGE;
      DC_LEADOFF_FLAG <= ecg_on && DC_LEADOFF_DETECT &&
        (fld2(config_reg, afegc_pkg::POS_DC_LEADOFF_ENABLE) == afegc_pkg::DCLO_ON);
    end
  end

  // ==========================================================================
  // Lead-off current, threshold and resistive bias decode
  // ==========================================================================
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      LEADOFF_SOURCE_CONNECTED <= 1'b0;
      POSITIVE_INPUT_PULLUP <= 1'b0;
      LEADOFF_CURRENT_NA <= 7'h00;
      LEADOFF_THRESHOLD_MV <= 10'h000;
      RESISTIVE_BIAS_MODE <= 2'h0;
      BIAS_RESISTOR_MOHM <= 8'h00;
      POSITIVE_INPUT_BIAS <= 1'b0;
      NEGATIVE_INPUT_BIAS <= 1'b0;
    end else begin
      LEADOFF_SOURCE_CONNECTED <= config_reg[afegc_pkg::POS_LEADOFF_MAGNITUDE +: 3] != 3'h0;
      POSITIVE_INPUT_PULLUP <= !config_reg[afegc_pkg::POS_LEADOFF_POLARITY] &&
        (config_reg[afegc_pkg::POS_LEADOFF_MAGNITUDE +: 3] != 3'h0);
      case (config_reg[afegc_pkg::POS_LEADOFF_MAGNITUDE +: 3])
        3'h1: LEADOFF_CURRENT_NA <= 7'h05;
        3'h2: LEADOFF_CURRENT_NA <= 7'h0a;
        3'h3: LEADOFF_CURRENT_NA <= 7'h14;
        3'h4: LEADOFF_CURRENT_NA <= 7'h32;
        3'h5: LEADOFF_CURRENT_NA <= 7'h64;
        default: LEADOFF_CURRENT_NA <= 7'h00;
      endcase
      case (fld2(config_reg, afegc_pkg::POS_LEADOFF_THRESHOLD))
        2'h0: LEADOFF_THRESHOLD_MV <= 10'h12c;
        2'h1: LEADOFF_THRESHOLD_MV <= 10'h190;
        2'h2: LEADOFF_THRESHOLD_MV <= 10'h1c2;
        default: LEADOFF_THRESHOLD_MV <= 10'h1f4;
      endcase
      RESISTIVE_BIAS_MODE <= fld2(config_reg, afegc_pkg::POS_RESISTIVE_BIAS_MODE);
      case (fld2(config_reg, afegc_pkg::POS_BIAS_RESISTOR_VALUE))
        2'h0: BIAS_RESISTOR_MOHM <= 8'h32;
        2'h1: BIAS_RESISTOR_MOHM <= 8'h64;
        2'h2: BIAS_RESISTOR_MOHM <= 8'hc8;
        default: BIAS_RESISTOR_MOHM <= 8'h00;
      endcase
      POSITIVE_INPUT_BIAS <= config_reg[afegc_pkg::POS_POSITIVE_INPUT_BIAS];
      NEGATIVE_INPUT_BIAS <= config_reg[afegc_pkg::POS_NEGATIVE_INPUT_BIAS];
    end
  end

  // ==========================================================================
  // Master clock and derived timing
  // ==========================================================================
  afegc_master_clock u_mclk (
    .CLK(CLK),
    .RST_N(RST_N),
    .ref_tick(REF_TICK),
    .select(clk_sel),
    .master_tick(MASTER_TICK)
  );

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      TIMING_RESOLUTION_NS <= afegc_pkg::TRES_NS_00;
      CALIBRATION_RESOLUTION_NS <= afegc_pkg::CALRES_NS_00;
      PACE_RECORD_DEPTH <= afegc_pkg::PACE_DEPTH_128;
    end else begin
      case (clk_sel)
        2'h0: begin
          TIMING_RESOLUTION_NS <= afegc_pkg::TRES_NS_00;
          CALIBRATION_RESOLUTION_NS <= afegc_pkg::CALRES_NS_00;
        end
        2'h3: begin
          TIMING_RESOLUTION_NS <= afegc_pkg::TRES_NS_11;
          CALIBRATION_RESOLUTION_NS <= afegc_pkg::CALRES_NS_11;
        end
        default: begin
          TIMING_RESOLUTION_NS <= afegc_pkg::TRES_NS_01;
          CALIBRATION_RESOLUTION_NS <= afegc_pkg::CALRES_NS_01;
        end
      endcase
      if (clk_sel[1]) begin
        PACE_RECORD_DEPTH <= afegc_pkg::PACE_DEPTH_320;
      end else if (CARDIAC_RATE_SEL == 2'h0) begin
        PACE_RECORD_DEPTH <= afegc_pkg::PACE_DEPTH_128;
      end else if (CARDIAC_RATE_SEL == 2'h1) begin
        PACE_RECORD_DEPTH <= 10'(afegc_pkg::PACE_DEPTH_128 << 1);
      end else begin
        PACE_RECORD_DEPTH <= 10'(afegc_pkg::PACE_DEPTH_128 << 2);
      end
    end
  end

  // Cardiac pacing: codes 00/01 allow full, half, quarter; codes 10/11 only the 200 class.
  always_comb begin
    ecg_div = {2'h0, afegc_pkg::ECG_DIV_FAST};
    if (clk_sel[1]) begin
      ecg_div = {2'h0, afegc_pkg::ECG_DIV_200};
    end else if (CARDIAC_RATE_SEL == 2'h1) begin
      ecg_div = {1'b0, afegc_pkg::ECG_DIV_FAST, 1'b0};
    end else if (CARDIAC_RATE_SEL[1]) begin
      ecg_div = {afegc_pkg::ECG_DIV_FAST, 2'h0};
    end
    ecg_div_full = ecg_div;
    bioz_div = {1'b0, afegc_pkg::BIOZ_DIV_512};
    if (clk_sel[1]) begin
      bioz_div = {1'b0, afegc_pkg::BIOZ_DIV_640};
    end
    if (IMPEDANCE_RATE_SEL) begin
      bioz_div = {bioz_div[9:0], 1'b0};
    end
  end

  afegc_divider #(.W(10)) u_ecg_div (
    .CLK(CLK),
    .RST_N(RST_N),
    .run(ecg_on),
    .tick(MASTER_TICK),
    .div(ecg_div_full),
    .strobe(CARDIAC_SAMPLE_STROBE)
  );

  afegc_divider #(.W(11)) u_bioz_div (
    .CLK(CLK),
    .RST_N(RST_N),
    .run(bioz_on),
    .tick(MASTER_TICK),
    .div(bioz_div),
    .strobe(IMPEDANCE_SAMPLE_STROBE)
  );

  // ==========================================================================
  // Checks
  // ==========================================================================
  chk_bias_forced_off: assert property (@(posedge CLK) disable iff (!RST_N)
    (cfg_write && !REG_WDATA[19] && !REG_WDATA[18]) |=> (config_reg[5:4] == 2'h0))
    else $error("bias mode accepted without channel enable");
  chk_pace_needs_ecg: assert property (@(posedge CLK) disable iff (!RST_N)
    PACE_DETECT_ON |-> $past(ecg_on))
    else $error("pace detection on with cardiac channel off");
  chk_ulp_lead_on: assert property (@(posedge CLK) disable iff (!RST_N)
    LOW_POWER_LEAD_ON_ACTIVE |-> !$past(config_reg[19]))
    else $error("low power lead-on active with cardiac on");
  chk_over_range_gate: assert property (@(posedge CLK) disable iff (!RST_N)
    IMPEDANCE_OVER_RANGE_FLAG |-> ($past(bioz_on) && $past(bloff[1])))
    else $error("over range flag without enabled detection");
  chk_under_range_gate: assert property (@(posedge CLK) disable iff (!RST_N)
    IMPEDANCE_UNDER_RANGE_FLAG |-> ($past(bioz_on) && $past(bloff[0])))
    else $error("under range flag without enabled detection");
  chk_dc_leadoff_gate: assert property (@(posedge CLK) disable iff (!RST_N)
    DC_LEADOFF_FLAG |-> $past(config_reg[13:12] == 2'h1 && ecg_on))
    else $error("dc lead-off flag while disabled");
  chk_readback_word: assert property (@(posedge CLK) disable iff (!RST_N)
    (REG_RD && REG_ADDR == 7'h10) |=> (REG_RVALID && REG_RDATA == $past(config_reg)))
    else $error("read back differs from register");
  chk_pace_depth_slow: assert property (@(posedge CLK) disable iff (!RST_N)
    (clk_sel[1] && $stable(clk_sel)) |=> (PACE_RECORD_DEPTH == 10'h140))
    else $error("pace depth not 320 for codes 10 and 11");

  // ==========================================================================
  // Derived output checks
  // ==========================================================================
  chk_ecg_strobe_off: assert property (@(posedge CLK) disable iff (!RST_N)
    !ecg_on |=> !CARDIAC_SAMPLE_STROBE)
    else $error("cardiac strobe while channel off");
  chk_imp_strobe_off: assert property (@(posedge CLK) disable iff (!RST_N)
    !bioz_on |=> !IMPEDANCE_SAMPLE_STROBE)
    else $error("impedance strobe while channel off");
  chk_ecg_bias_gate: assert property (@(posedge CLK) disable iff (!RST_N)
    (RESISTIVE_BIAS_MODE == afegc_pkg::BIAS_CARDIAC) |-> $past(ecg_on))
    else $error("cardiac bias without cardiac channel");
  chk_imp_bias_gate: assert property (@(posedge CLK) disable iff (!RST_N)
    (RESISTIVE_BIAS_MODE == afegc_pkg::BIAS_IMPEDANCE) |-> $past(bioz_on))
    else $error("impedance bias without impedance channel");
  chk_spare_bit_zero: assert property (@(posedge CLK) disable iff (!RST_N)
    !config_reg[afegc_pkg::POS_UNUSED])
    else $error("spare bit stored as one");
  chk_tres_code00: assert property (@(posedge CLK) disable iff (!RST_N)
    (clk_sel == 2'h0) |=> (TIMING_RESOLUTION_NS == afegc_pkg::TRES_NS_00))
    else $error("timing resolution wrong for code 00");
  chk_calres_code11: assert property (@(posedge CLK) disable iff (!RST_N)
    (clk_sel == 2'h3) |=> (CALIBRATION_RESOLUTION_NS == afegc_pkg::CALRES_NS_11))
    else $error("calibration resolution wrong for code 11");
  chk_tick_needs_ref: assert property (@(posedge CLK) disable iff (!RST_N)
    !REF_TICK |=> !MASTER_TICK)
    else $error("master tick without reference tick");
  chk_source_off: assert property (@(posedge CLK) disable iff (!RST_N)
    (config_reg[10:8] == 3'h0) |=> (LEADOFF_CURRENT_NA == 7'h00 && !POSITIVE_INPUT_PULLUP))
    else $error("lead-off source active while disconnected");
  chk_bias_value_mid: assert property (@(posedge CLK) disable iff (!RST_N)
    (config_reg[3:2] == 2'h1) |=> (BIAS_RESISTOR_MOHM == 8'h64))
    else $error("bias resistor not 100 for code 01");

endmodule // afegc_general_config

// ===== hdl/afegc_master_clock.sv
// Master clock tick generator derived from the low frequency reference tick.
`timescale 1ns/1ps
module afegc_master_clock (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic ref_tick,
  input wire logic [1:0] select,
  output logic master_tick
);

  logic [16:0] acc_reg;
  logic [16:0] acc_next;
  logic [16:0] den;
  logic [16:0] num;
  logic keep;

  // ==========================================================================
  // Fractional tick dropping
  // ==========================================================================
  always_comb begin
    den = 17'h00001;
    num = 17'h00001;
    if (select == 2'h0) begin
      den = 17'h00001;
      num = 17'h00001;
    end else if (select == 2'h3) begin
      den = afegc_pkg::MCLK_DEN_31968;
      num = {1'b0, afegc_pkg::MCLK_NUM_31968};
    end else begin
      den = {1'b0, afegc_pkg::MCLK_DEN_32000};
      num = {1'b0, afegc_pkg::MCLK_NUM_32000};
    end
    keep = (acc_reg + num) >= den;
    acc_next = keep ? (acc_reg + num - den) : (acc_reg + num);
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      acc_reg <= 17'h00000;
      master_tick <= 1'b0;
    end else begin
      master_tick <= ref_tick && keep;
      if (ref_tick) begin
        acc_reg <= (acc_next >= den) ? 17'h00000 : acc_next;
      end
    end
  end

  chk_full_rate_pass: assert property (@(posedge CLK) disable iff (!RST_N)
    (ref_tick && select == 2'h0) |=> master_tick)
    else $error("master tick missing at full rate");

endmodule // afegc_master_clock

// ===== hdl/afegc_pkg.sv
// Package with the general configuration register layout, reset values and clock ratios.
package afegc_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [6:0] ADDR_GENERAL_CONFIG = 7'h10;
  localparam int DATA_W = 24;
  localparam logic [23:0] GENERAL_CONFIG_RESET = 24'h000004;
  localparam logic [23:0] GENERAL_CONFIG_WMASK = 24'hfeffff;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int POS_LOW_POWER_LEAD_ON = 22;
  localparam int POS_MASTER_CLOCK_SELECT = 20;
  localparam int POS_CARDIAC_ON = 19;
  localparam int POS_IMPEDANCE_ON = 18;
  localparam int POS_PACE_ON = 17;
  localparam int POS_UNUSED = 16;
  localparam int POS_IMP_LEADOFF_MODE = 14;
  localparam int POS_DC_LEADOFF_ENABLE = 12;
  localparam int POS_LEADOFF_POLARITY = 11;
  localparam int POS_LEADOFF_MAGNITUDE = 8;
  localparam int POS_LEADOFF_THRESHOLD = 6;
  localparam int POS_RESISTIVE_BIAS_MODE = 4;
  localparam int POS_BIAS_RESISTOR_VALUE = 2;
  localparam int POS_POSITIVE_INPUT_BIAS = 1;
  localparam int POS_NEGATIVE_INPUT_BIAS = 0;

  // ==========================================================================
  // Codes
  // ==========================================================================
  localparam logic [1:0] BIAS_OFF = 2'h0;
  localparam logic [1:0] BIAS_CARDIAC = 2'h1;
  localparam logic [1:0] BIAS_IMPEDANCE = 2'h2;
  localparam logic [1:0] DCLO_ON = 2'h1;
  localparam logic [1:0] ULP_ON = 2'h1;

  // ==========================================================================
  // Master clock derivation from the 32768 Hz reference
  // ==========================================================================
  // Master ticks are produced by dropping reference ticks: keep num out of den.
  localparam int REF_FREQ_HZ = 32768;
  localparam logic [15:0] MCLK_NUM_32000 = 16'h03e8;  // 1000 of 1024.
  localparam logic [15:0] MCLK_DEN_32000 = 16'h0400;
  localparam logic [15:0] MCLK_NUM_31968 = 16'h0028;  // 40 of 41 -> 31968.78 Hz.
  localparam logic [16:0] MCLK_DEN_31968 = 17'h00029;

  // Timing resolution in nanoseconds, per master clock code.
  localparam logic [15:0] TRES_NS_00 = 16'h3b9c;  // 15260 ns.
  localparam logic [15:0] TRES_NS_01 = 16'h3d0e;  // 15630 ns.
  localparam logic [15:0] TRES_NS_11 = 16'h3d18;  // 15640 ns.
  localparam logic [15:0] CALRES_NS_00 = 16'h7738;  // 30520 ns.
  localparam logic [15:0] CALRES_NS_01 = 16'h7a12;  // 31250 ns.
  localparam logic [15:0] CALRES_NS_11 = 16'h7a30;  // 31280 ns.

  // Master clock ticks per cardiac sample (fastest rate of each code).
  localparam logic [7:0] ECG_DIV_FAST = 8'h40;   // 32768/64 = 512, 32000/64 = 500.
  localparam logic [7:0] ECG_DIV_200 = 8'ha0;    // 32000/160 = 200.
  localparam logic [9:0] PACE_DEPTH_320 = 10'h140;
  localparam logic [9:0] PACE_DEPTH_128 = 10'h080;
  // Master clock ticks per impedance sample at rate setting 0.
  localparam logic [9:0] BIOZ_DIV_512 = 10'h200;  // 64 or 62.5 sps.
  localparam logic [9:0] BIOZ_DIV_640 = 10'h280;  // 50 sps.

  typedef enum logic [2:0] {
    AFEGC_ECG_FULL = 3'b001,
    AFEGC_ECG_HALF = 3'b010,
    AFEGC_ECG_QUARTER = 3'b100
  } afegc_rate_e;

endpackage : afegc_pkg

// ===== verification/afe_general_config_register_tb.sv
// Self-checking bench for the general configuration register.
`timescale 1ns/1ps
module afe_general_config_register_tb;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ref_tick = 1'b0;
  logic imp_rs = 1'b0;
  logic ov = 1'b0;
  logic un = 1'b0;
  logic dc = 1'b0;
  logic [1:0] rate = 2'h0;
  logic wr, rd, rvalid, mtick, c_on, i_on, p_on, b_on, ulp, ovf, unf, dcf;
  logic src, pu, pb, nb, cs, is;
  logic [6:0] addr, na;
  logic [23:0] wdata, rdata, rd_word, cur;
  logic [9:0] mv, depth;
  logic [1:0] rb;
  logic [7:0] mohm;
  logic [15:0] tres, cres;
  logic [31:0] seed = 32'hf35c3023;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int mt_cnt = 0;
  bit cnt_en = 1'b0;
  int na_t[8] = '{0, 5, 10, 20, 50, 100, 0, 0};
  int mv_t[4] = '{300, 400, 450, 500};
  int mo_t[4] = '{50, 100, 200, 0};
  int tr_t[4] = '{15260, 15630, 15630, 15640};
  int cr_t[4] = '{30520, 31250, 31250, 31280};
  logic [23:0] corner[6] = '{24'h0c0020, 24'h000010, 24'h0a0000, 24'h020000, 24'h41000f,
                             24'h3fffff};

  afegc_general_config dut (.CLK(clk), .RST_N(rst_n), .REG_WR(wr), .REG_RD(rd),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .REF_TICK(ref_tick), .CARDIAC_RATE_SEL(rate), .IMPEDANCE_RATE_SEL(imp_rs),
    .IMP_OVER_RANGE(ov), .IMP_UNDER_RANGE(un), .DC_LEADOFF_DETECT(dc), .MASTER_TICK(mtick),
    .CARDIAC_CHANNEL_ON(c_on), .IMPEDANCE_CHANNEL_ON(i_on), .PACE_DETECT_ON(p_on),
    .BEAT_INTERVAL_ON(b_on), .LOW_POWER_LEAD_ON_ACTIVE(ulp), .IMPEDANCE_OVER_RANGE_FLAG(ovf),
    .IMPEDANCE_UNDER_RANGE_FLAG(unf), .DC_LEADOFF_FLAG(dcf), .LEADOFF_SOURCE_CONNECTED(src),
    .POSITIVE_INPUT_PULLUP(pu), .LEADOFF_CURRENT_NA(na), .LEADOFF_THRESHOLD_MV(mv),
    .RESISTIVE_BIAS_MODE(rb), .BIAS_RESISTOR_MOHM(mohm), .POSITIVE_INPUT_BIAS(pb),
    .NEGATIVE_INPUT_BIAS(nb), .TIMING_RESOLUTION_NS(tres), .CALIBRATION_RESOLUTION_NS(cres),
    .PACE_RECORD_DEPTH(depth), .CARDIAC_SAMPLE_STROBE(cs), .IMPEDANCE_SAMPLE_STROBE(is));

  afegc_host_model host (.CLK(clk), .WR(wr), .RD(rd), .ADDR(addr), .WDATA(wdata),
    .RDATA(rdata), .RVALID(rvalid));

  // ==========================================================================
  // Clock, reference ticks and counters
  // ==========================================================================
  initial begin
    forever #5 clk = ~clk;
  end
  always @(negedge clk) begin
    cyc <= cyc + 1;
    ref_tick <= (cyc % 2) == 0;
  end
  always @(posedge clk) if (cnt_en && mtick === 1'b1) mt_cnt++;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [31:0] lfsr();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  // Stored image of a written word: spare bit dropped, bias mode needs its channel.
  function automatic logic [23:0] keep(input logic [23:0] w);
    logic [23:0] r;
    r = w;
    r[16] = 1'b0;
    if ((w[5:4] == 2'h1 && !w[19]) || (w[5:4] == 2'h2 && !w[18])) r[5:4] = 2'h0;
    return r;
  endfunction

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cfg_test(input logic [23:0] w);
    logic [23:0] s;
    s = keep(w);
    cur = s;
    host.wr(7'h10, w);
    host.wr(7'h09, 24'h000000);
    repeat (2) @(negedge clk);
    host.rd(7'h10, rd_word);
    check("readback", rd_word, s);
    check("cardiac_on", 24'(c_on), 24'(s[19]));
    check("beat_on", 24'(b_on), 24'(s[19]));
    check("imp_on", 24'(i_on), 24'(s[18]));
    check("pace_on", 24'(p_on), 24'(s[17] & s[19]));
    check("ulp", 24'(ulp), 24'(s[22] & !s[19]));
    check("over", 24'(ovf), 24'(ov & s[18] & s[15]));
    check("under", 24'(unf), 24'(un & s[18] & s[14]));
    check("dc_flag", 24'(dcf), 24'(dc & s[19] & s[12]));
    check("src", 24'(src), 24'(|s[10:8]));
    check("pullup", 24'(pu), 24'(!s[11] & |s[10:8]));
    check("na", 24'(na), 24'(na_t[s[10:8]]));
    check("mv", 24'(mv), 24'(mv_t[s[7:6]]));
    check("bias_mode", 24'(rb), 24'(s[5:4]));
    check("mohm", 24'(mohm), 24'(mo_t[s[3:2]]));
    check("pos_bias", 24'(pb), 24'(s[1]));
    check("neg_bias", 24'(nb), 24'(s[0]));
    check("tres", 24'(tres), 24'(tr_t[s[21:20]]));
    check("cres", 24'(cres), 24'(cr_t[s[21:20]]));
    check("depth", 24'(depth), s[21] ? 24'd320 : 24'(128 << (rate[1] ? 2 : rate)));
  endtask

  task automatic gap(input bit imp, input int exp);
    int t[3];
    for (int i = 0; i < 3; i++) begin
      do @(negedge clk); while ((imp ? is : cs) !== 1'b1);
      t[i] = cyc;
    end
    check("strobe_gap", 24'(t[2] - t[1]), 24'(exp));
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    logic [31:0] r;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    host.rd(7'h10, rd_word);
    check("reset_word", rd_word, 24'h000004);
    check("reset_mohm", 24'(mohm), 24'd100);
    $display("test reset done");
    for (int i = 0; i < 30; i++) begin
      r = lfsr();
      {ov, un, dc, imp_rs} = r[3:0];
      rate = r[5:4];
      r = lfsr();
      cfg_test(host.legal(i < 6 ? corner[i] : r[23:0]));
    end
    $display("test fields done");
    host.wr(7'h11, 24'hffffff);
    host.rd(7'h11, rd_word);
    check("unmapped_rd", rd_word, 24'h000000);
    host.rd(7'h10, rd_word);
    check("unmapped_wr", rd_word, cur);
    $display("test unmapped done");
    for (int k = 0; k < 4; k++) begin
      host.wr(7'h10, {2'h0, 2'(k), 20'h80000});
      repeat (8) @(negedge clk);
      mt_cnt = 0;
      cnt_en = 1'b1;
      // Code 11 keeps 40 of 41 reference ticks, so its window spans 1025 of them.
      repeat (k == 3 ? 2050 : 2048) @(negedge clk);
      cnt_en = 1'b0;
      check("master_ticks", 24'(mt_cnt), k ? 24'd1000 : 24'd1024);
    end
    $display("test master clock done");
    rate = 2'h0;
    imp_rs = 1'b0;
    host.wr(7'h10, 24'h0c0000);
    gap(1'b0, 128);
    gap(1'b1, 1024);
    imp_rs = 1'b1;
    gap(1'b1, 2048);
    rate = 2'h2;
    gap(1'b0, 512);
    $display("test strobes done");
    end_sim();
  end

  initial begin
    #500000;
    n_errors++;
    end_sim();
  end
endmodule  // afe_general_config_register_tb

// ===== verification/afegc_host_model.sv
// Host model that drives the register port and keeps the software coding limits.
`timescale 1ns/1ps
module afegc_host_model (
  input wire logic CLK,
  output logic WR,
  output logic RD,
  output logic [6:0] ADDR,
  output logic [23:0] WDATA,
  input wire logic [23:0] RDATA,
  input wire logic RVALID
);
  initial begin
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 7'h00;
    WDATA = 24'h000000;
  end

  // Turns any word into one that software may write.
  function automatic logic [23:0] legal(input logic [23:0] w);
    logic [23:0] r;
    r = w;
    r[23] = 1'b0;
    r[13] = 1'b0;
    if (r[10:8] > 3'h5) r[10:8] = 3'h5;
    if (r[5:4] == 2'h3) r[5:4] = 2'h0;
    if (r[3:2] == 2'h3) r[3:2] = 2'h2;
    return r;
  endfunction

  task automatic wr(input logic [6:0] a, input logic [23:0] d);
    @(negedge CLK);
    WR = 1'b1;
    ADDR = a;
    WDATA = d;
    @(negedge CLK);
    WR = 1'b0;
    ADDR = ~a;
    WDATA = ~d;
  endtask

  task automatic rd(input logic [6:0] a, output logic [23:0] d);
    @(negedge CLK);
    RD = 1'b1;
    ADDR = a;
    @(negedge CLK);
    RD = 1'b0;
    ADDR = ~a;
    d = (RVALID === 1'b1) ? RDATA : 24'hxxxxxx;
  endtask
endmodule  // afegc_host_model
